/* File: hw/spc_pkg.sv */
// Package with register map, field layout, reset values and timing constants
package spc_pkg;
  // Register byte offsets
  localparam logic [7:0] SPC_CTRL_OFS = 8'h00;
  localparam logic [7:0] SPC_SCAN_OFS = 8'h04;
  localparam logic [7:0] SPC_RETAIN_OFS = 8'h08;
  localparam logic [7:0] SPC_STATUS_OFS = 8'h0c;
  // Control register fields
  localparam int SPC_CTRL_AUTOSTART = 0;
  localparam int SPC_CTRL_CARD = 1;
  localparam int SPC_CTRL_GO_RUN = 2;
  localparam int SPC_CTRL_GO_STOP = 3;
  localparam logic SPC_AUTOSTART_RST = 1'b1;
  localparam logic SPC_CARD_RST = 1'b0;
  // Scan period, in milliseconds
  localparam int SPC_PERIOD_W = 6;
  localparam logic [5:0] SPC_PERIOD_RST = 6'h00;
  localparam logic [5:0] SPC_PERIOD_MAX = 6'h3c;
  // Retention groups, one bit each
  localparam int SPC_GRP_W = 10;
  localparam logic [9:0] SPC_RETAIN_RST = 10'h000;
  localparam int SPC_GRP_M9_M12 = 0;
  localparam int SPC_GRP_M13_M16 = 1;
  localparam int SPC_GRP_N9_N16 = 2;
  localparam int SPC_GRP_C5_C7 = 3;
  localparam int SPC_GRP_C8 = 4;
  localparam int SPC_GRP_C13_C16 = 5;
  localparam int SPC_GRP_D1_D8 = 6;
  localparam int SPC_GRP_T7 = 7;
  localparam int SPC_GRP_T8 = 8;
  localparam int SPC_GRP_T13_T16 = 9;
  // Status register fields
  localparam int SPC_ST_RUN = 0;
  localparam int SPC_ST_LOADING = 1;
  localparam int SPC_ST_REJECT = 2;
  localparam int SPC_ST_LOCKREF = 3;
  localparam int SPC_ST_CHECK = 4;
  // Timing: one millisecond at a 100 MHz clock
  localparam int SPC_CLK_MHZ = 100;
  localparam int SPC_MS_US = 1000;
  localparam int SPC_CYC_PER_MS = SPC_MS_US * SPC_CLK_MHZ;
  // Rated write endurance of the retention store
  localparam int SPC_NV_ENDURANCE = 1000000;
  // Sequencer states
  typedef enum logic [3:0] {
    SPC_CHECK = 4'b0001,
    SPC_LOAD = 4'b0010,
    SPC_RUN = 4'b0100,
    SPC_STOP = 4'b1000
  } spc_state_t;
endpackage

/* File: hw/spc_startup_scan.sv */
// Startup mode sequencer, scan period pacer and retention selector
// What this block does
// (R1) Program transfers never alter startup settings
// (R2) Displayless variants always autostart into RUN
// (R3) No program or autostart cleared: stay STOP
// (R4) Card mode: RUN only with valid module
// (R5) Card mode, differing program: load, then RUN
// (R6) Card mode off after reset
// (R7) Card mode only with newest module type
// (R8) Password lock refuses settings writes
// (R9) Minimum scan period resets to zero
// (R10) Period changes accepted in STOP only
// (R11) Each scan lasts at least the period
// (R12) Zero period: scans back to back
// (R13) Period accepted only from 0 to 60
// (R14) Retention disabled for all groups at reset
// (R15) Retained values persist until overwritten
// (R16) Only ten fixed groups are selectable
// (R17) Retention chosen per group, not element
// (R18) Store retained values at every switch-off
// (R19) Autostart set at reset enters RUN
// (R20) Non-retained values cleared in STOP
// (R21) Check program and module, hold decision
//
// Added by the designer: the AHB-Lite register port and the address map.
`timescale 1ns/10ps
module spc_startup_scan #(
  parameter int CYC_PER_MS = spc_pkg::SPC_CYC_PER_MS
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Device and program status
  input wire logic has_display,
  input wire logic prog_valid,
  input wire logic sys_locked,
  input wire logic power_fail,
  // Removable program module
  input wire logic mod_present,
  input wire logic mod_prog_valid,
  input wire logic mod_newest,
  input wire logic mod_differs,
  input wire logic load_done,
  output logic load_req,
  // Program engine
  input wire logic scan_done,
  output logic scan_start,
  output logic run_mode,
  // Retention store
  output logic [spc_pkg::SPC_GRP_W-1:0] retain_mask,
  output logic nv_store,
  output logic clear_volatile
);
  import spc_pkg::*;

  // Refuse a millisecond divider that the tick compare cannot serve
  if (CYC_PER_MS < 2) begin : g_bad_cyc_per_ms
    $error("CYC_PER_MS must be at least 2");
  end

  spc_state_t state;
  spc_state_t next_state;
  logic autostart;
  logic card_mode;
  logic [SPC_PERIOD_W-1:0] period;
  logic reject_flag;
  logic lockref_flag;
  logic disp_seen;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic [31:0] cyc_cnt;
  logic [SPC_PERIOD_W:0] ms_cnt;
  logic scan_busy;
  logic pf_d;

  // Bus decode
  wire addr_phase = hsel & htrans[1] & hready;
  wire [7:0] a_ofs = haddr[7:0];
  wire [7:0] w_ofs = wr_addr;
  wire wr_ctrl = wr_pend & (w_ofs == SPC_CTRL_OFS);
  wire wr_scan = wr_pend & (w_ofs == SPC_SCAN_OFS);
  wire wr_retain = wr_pend & (w_ofs == SPC_RETAIN_OFS);
  wire wr_sys = wr_ctrl | wr_scan | wr_retain;
  wire wr_ok = wr_sys & ~sys_locked; // R8
  wire in_stop = (state == SPC_STOP);
  wire [SPC_PERIOD_W-1:0] new_period = hwdata[SPC_PERIOD_W-1:0];
  wire period_in_range = (hwdata[31:SPC_PERIOD_W] == '0) && (new_period <= SPC_PERIOD_MAX); // R13
  wire period_ok = wr_ok & wr_scan & in_stop & period_in_range; // R10 R13
  wire period_bad = wr_ok & wr_scan & ~(in_stop & period_in_range); // R10 R13
  wire go_run = wr_ok & wr_ctrl & hwdata[SPC_CTRL_GO_RUN];
  wire go_stop = wr_ok & wr_ctrl & hwdata[SPC_CTRL_GO_STOP];

  // Startup decision terms
  wire disp_now = (state == SPC_CHECK) ? has_display : disp_seen; // R2
  wire auto_eff = autostart | ~disp_now; // R2 R19
  wire card_eff = card_mode & (~mod_present | mod_newest); // R7 R4
  wire mod_ok = mod_present & mod_prog_valid; // R4
  wire pf_rise = power_fail & ~pf_d;
  wire pf_fall = ~power_fail & pf_d; // R21

  // Scan pacing terms
  wire ms_tick = (cyc_cnt == 32'(CYC_PER_MS - 1));
  wire period_met = (ms_cnt >= {1'b0, period}); // R11 R12
  wire launch = (state == SPC_RUN) & ~scan_busy & ~scan_start & period_met; // R11 R12

  // Read data select
  function automatic logic [31:0] spc_read(input logic [7:0] ofs);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (ofs)
      SPC_CTRL_OFS: begin
        r[SPC_CTRL_AUTOSTART] = autostart;
        r[SPC_CTRL_CARD] = card_mode;
      end
      SPC_SCAN_OFS: r[SPC_PERIOD_W-1:0] = period;
      SPC_RETAIN_OFS: r[SPC_GRP_W-1:0] = retain_mask; // R17
      SPC_STATUS_OFS: begin
        r[SPC_ST_RUN] = run_mode;
        r[SPC_ST_LOADING] = load_req;
        r[SPC_ST_REJECT] = reject_flag;
        r[SPC_ST_LOCKREF] = lockref_flag;
        r[SPC_ST_CHECK] = (state == SPC_CHECK);
      end
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  // Bus slave: zero wait states, always OKAY
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend <= addr_phase & hwrite & (haddr[31:8] == '0);
      wr_addr <= a_ofs;
      if (addr_phase & ~hwrite) begin
        hrdata <= (haddr[31:8] == '0) ? spc_read(a_ofs) : 32'h0000_0000;
      end
    end
  end

  // Settings registers; program transfers never touch them
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      autostart <= SPC_AUTOSTART_RST; // R19
      card_mode <= SPC_CARD_RST; // R6
      period <= SPC_PERIOD_RST; // R9
      retain_mask <= SPC_RETAIN_RST; // R14
    end else begin
      if (wr_ok & wr_ctrl) begin // R1
        autostart <= hwdata[SPC_CTRL_AUTOSTART];
        card_mode <= hwdata[SPC_CTRL_CARD];
      end
      if (period_ok) begin
        period <= new_period; // R10 R13
      end
      if (wr_ok & wr_retain) begin
        retain_mask <= hwdata[SPC_GRP_W-1:0]; // R16 R17
      end
    end
  end

  // Sticky error flags; a write to status clears, a new event wins
  wire clr_flags = wr_pend & (w_ofs == SPC_STATUS_OFS);
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      reject_flag <= 1'b0;
      lockref_flag <= 1'b0;
    end else begin
      reject_flag <= period_bad | (reject_flag & ~clr_flags);
      lockref_flag <= (wr_sys & sys_locked) | (lockref_flag & ~clr_flags); // R8
    end
  end

  // Power-up sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      SPC_CHECK: begin
        if (card_eff) begin
          if (!mod_ok) begin
            next_state = SPC_STOP; // R4
          end else if (mod_differs) begin
            next_state = SPC_LOAD; // R5
          end else begin
            next_state = SPC_RUN; // R4
          end
        end else if (prog_valid & auto_eff) begin
          next_state = SPC_RUN; // R19 R2
        end else begin
          next_state = SPC_STOP; // R3
        end
      end
      SPC_LOAD: begin
        if (load_done) begin
          next_state = SPC_RUN; // R5
        end
      end
      SPC_RUN: begin
        if (go_stop) begin
          next_state = SPC_STOP; // R21
        end
      end
      SPC_STOP: begin
        if (go_run & prog_valid) begin
          next_state = SPC_RUN; // R21
        end
      end
    endcase
    // Supply returning re-runs the startup check
    if (pf_fall) begin
      next_state = SPC_CHECK; // R21
    end
  end

  // State register and display strap, caught after reset release
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state <= SPC_CHECK;
      disp_seen <= 1'b1;
      load_req <= 1'b0;
      run_mode <= 1'b0;
      clear_volatile <= 1'b1;
    end else begin
      state <= next_state; // R21
      if (state == SPC_CHECK) begin
        disp_seen <= has_display; // R2
      end
      load_req <= (next_state == SPC_LOAD); // R5
      run_mode <= (next_state == SPC_RUN);
      clear_volatile <= (next_state != SPC_RUN); // R20
    end
  end

  // Scan pacer: millisecond timer restarted at each scan start
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cyc_cnt <= 32'h0000_0000;
      ms_cnt <= '0;
      scan_busy <= 1'b0;
      scan_start <= 1'b0;
    end else begin
      scan_start <= launch; // R11
      if (launch) begin
        cyc_cnt <= 32'h0000_0000;
        ms_cnt <= '0;
      end else if (ms_tick) begin
        cyc_cnt <= 32'h0000_0000;
        if (!ms_cnt[SPC_PERIOD_W]) begin
          ms_cnt <= ms_cnt + 1'b1;
        end
      end else begin
        cyc_cnt <= cyc_cnt + 32'h0000_0001;
      end
      if (state != SPC_RUN) begin
        scan_busy <= 1'b0;
      end else if (scan_start) begin
        scan_busy <= 1'b1;
      end else if (scan_done) begin
        scan_busy <= 1'b0; // R12
      end
    end
  end

  // Retention store pulse on each supply switch-off while any group is retained
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pf_d <= 1'b0;
      nv_store <= 1'b0;
    end else begin
      pf_d <= power_fail;
      nv_store <= pf_rise & (retain_mask != SPC_RETAIN_RST); // R18 R15
    end
  end

  // Cycles since the last scan start, for the pacing check
  // Counted in every state but valid only while RUN holds; a fresh RUN entry starts unpaced
  logic [31:0] gap_cnt;
  logic gap_valid;
  wire [31:0] min_gap = 32'(period) * 32'(CYC_PER_MS); // R11
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      gap_cnt <= 32'h0000_0000;
      gap_valid <= 1'b0;
    end else begin
      if (scan_start) begin
        gap_cnt <= 32'h0000_0001;
      end else if (gap_cnt != 32'hffff_ffff) begin
        gap_cnt <= gap_cnt + 32'h0000_0001;
      end
      gap_valid <= (state == SPC_RUN) & (scan_start | gap_valid);
    end
  end

  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (srst);

  AST_CARD_NEEDS_MODULE: assert property ( // R4
    (state == SPC_CHECK) && card_eff && !mod_ok |=> (state == SPC_STOP))
    else $error("card mode without valid module left STOP");
  AST_LOAD_THEN_RUN: assert property ( // R5
    (state == SPC_LOAD) && load_done |=> (state == SPC_RUN) ##1 run_mode)
    else $error("module load did not lead to RUN");
  AST_NO_PROG_STOP: assert property ( // R3
    (state == SPC_CHECK) && !card_eff && !prog_valid |=> ##1 !run_mode)
    else $error("ran without a program");
  AST_OLD_MODULE: assert property ( // R7
    (state == SPC_CHECK) && mod_present && !mod_newest && prog_valid && auto_eff
    |=> (state == SPC_RUN))
    else $error("old module type affected startup");
  AST_LOCK_REFUSE: assert property ( // R8
    wr_sys && sys_locked |=> $stable(autostart) && $stable(period) && $stable(retain_mask))
    else $error("settings changed while locked");
  AST_PERIOD_RUN: assert property ( // R10
    (state != SPC_STOP) |=> $stable(period))
    else $error("period changed outside STOP");
  AST_PERIOD_MAX: assert property ( // R13
    period <= SPC_PERIOD_MAX)
    else $error("period above 60 ms");
  AST_SCAN_MIN: assert property ( // R11
    scan_start && (period != 6'h00) |-> !launch [*2])
    else $error("scan restarted too early");
  AST_ZERO_BACK: assert property ( // R12
    (state == SPC_RUN) && (next_state == SPC_RUN) && scan_busy && scan_done && (period == 6'h00)
    |=> ##1 scan_start)
    else $error("zero period scan delayed");
  AST_CLEAR_STOP: assert property ( // R20
    (state == SPC_STOP) |-> clear_volatile)
    else $error("volatile values kept in STOP");
  AST_NV_STORE: assert property ( // R18
    $rose(power_fail) && (retain_mask != 10'h000) |=> nv_store)
    else $error("retained values not stored at switch-off");
  // Startup decisions, refusals, pacing, hold and store cause
  AST_DISPLAYLESS_RUN: assert property ( // R2
    (state == SPC_CHECK) && !pf_fall && !card_eff && prog_valid && !has_display |=> run_mode)
    else $error("displayless variant did not start in RUN");
  AST_CARD_RUN: assert property ( // R4
    (state == SPC_CHECK) && !pf_fall && card_eff && mod_ok && !mod_differs |=> run_mode)
    else $error("card mode with valid module did not run");
  AST_CARD_LOAD: assert property ( // R5
    (state == SPC_CHECK) && !pf_fall && card_eff && mod_ok && mod_differs |=> load_req && !run_mode)
    else $error("differing module program not loaded first");
  AST_LOCK_FLAG: assert property ( // R8
    wr_sys && sys_locked |=> lockref_flag)
    else $error("locked settings write not flagged");
  AST_REJECT_RUN: assert property ( // R10
    wr_ok && wr_scan && !in_stop |=> reject_flag && $stable(period))
    else $error("period write outside STOP not refused");
  AST_SCAN_GAP: assert property ( // R11
    scan_start && gap_valid |-> (gap_cnt >= min_gap))
    else $error("scan started before the period elapsed");
  AST_POWER_RECHECK: assert property ( // R21
    pf_fall |=> (state == SPC_CHECK))
    else $error("supply return did not re-run the startup check");
  AST_HOLD_RUN: assert property ( // R21
    (state == SPC_RUN) && !go_stop && !pf_fall |=> (state == SPC_RUN))
    else $error("RUN left without a mode change");
  AST_STORE_CAUSE: assert property ( // R18
    nv_store |-> $past(power_fail) && !$past(pf_d))
    else $error("store pulse without a switch-off");
endmodule // spc_startup_scan

/* File: test/spc_card_model.sv */
// Removable program module model with status levels and copy handshake
`timescale 1ns/10ps
module spc_card_model (
  // Clock
  input wire logic ref_clk,
  // Fitted module setup: valid, newest, differs
  input wire logic fitted,
  input wire logic [2:0] cfg,
  // Device side
  input wire logic load_req,
  output logic mod_present,
  output logic mod_prog_valid,
  output logic mod_newest,
  output logic mod_differs,
  output logic load_done
);
  logic [2:0] copy_cnt;
  // Status levels, all low when no module is fitted
  assign mod_present = fitted;
  assign mod_prog_valid = fitted & cfg[0];
  assign mod_newest = fitted & cfg[1];
  assign mod_differs = fitted & cfg[2];
  // Copy takes a few cycles, then done stands while requested
  always_ff @(posedge ref_clk) begin
    copy_cnt <= load_req ? copy_cnt + ((copy_cnt != 3'h3) ? 3'h1 : 3'h0) : 3'h0;
  end
  assign load_done = load_req & (copy_cnt == 3'h3);
endmodule // spc_card_model

/* File: test/testbench.sv */
// Self-checking bench: startup, scan pacing and retention selection
`timescale 1ns/10ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module testbench;
  import spc_pkg::*;
  localparam int CPM = 8;
  logic ref_clk, srst, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize, cfg;
  logic has_display, prog_valid, sys_locked, power_fail, fitted;
  logic mp, mv, mn, md, load_done, load_req, scan_done, scan_start, run_mode;
  logic nv_store, clear_volatile;
  logic [SPC_GRP_W-1:0] retain_mask;
  logic [3:0] eng;
  int failures = 0, total_checks = 0, cyc = 0, n;
  spc_startup_scan #(.CYC_PER_MS(CPM)) uut (.ref_clk(ref_clk), .srst(srst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .has_display(has_display), .prog_valid(prog_valid), .sys_locked(sys_locked),
    .power_fail(power_fail), .mod_present(mp), .mod_prog_valid(mv), .mod_newest(mn),
    .mod_differs(md), .load_done(load_done), .load_req(load_req), .scan_done(scan_done),
    .scan_start(scan_start), .run_mode(run_mode), .retain_mask(retain_mask),
    .nv_store(nv_store), .clear_volatile(clear_volatile));
  spc_card_model card (.ref_clk(ref_clk), .fitted(fitted), .cfg(cfg), .load_req(load_req),
    .mod_present(mp), .mod_prog_valid(mv), .mod_newest(mn), .mod_differs(md),
    .load_done(load_done));
  assign hready = hreadyout;
  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Program engine: each scan takes five cycles
  always @(posedge ref_clk) begin
    eng <= {eng[2:0], scan_start};
    scan_done <= eng[3];
  end
  // Hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      tally_and_finish();
    end
  end
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge ref_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(nm, e, rd)
  endtask
  task automatic do_reset();
    srst <= 1'b1;
    repeat (6) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask
  // Cycles until the next scan start, bounded
  task automatic gap(output int c);
    c = 0;
    do begin
      @(posedge ref_clk);
      c++;
    end while (scan_start !== 1'b1 && c < 500);
  endtask
  task automatic t_defaults();
    rd_chk("ctrl", SPC_CTRL_OFS, 32'h1);
    `CHK("run", 1'b1, run_mode)
    `CHK("clear", 1'b0, clear_volatile)
    rd_chk("scan", SPC_SCAN_OFS, 32'h0);
    rd_chk("retain", SPC_RETAIN_OFS, 32'h0);
    rd_chk("bad addr", 8'h10, 32'h0);
    $display("test defaults done");
  endtask
  task automatic t_period();
    bus(1'b1, SPC_SCAN_OFS, 32'h5);
    rd_chk("scan in run", SPC_SCAN_OFS, 32'h0);
    rd_chk("reject flag", SPC_STATUS_OFS, 32'h5);
    bus(1'b1, SPC_STATUS_OFS, 32'h0);
    bus(1'b1, SPC_CTRL_OFS, 32'h9);
    @(posedge ref_clk);
    `CHK("stop", 1'b0, run_mode)
    `CHK("clear stop", 1'b1, clear_volatile)
    bus(1'b1, SPC_SCAN_OFS, 32'h3d);
    rd_chk("scan 61", SPC_SCAN_OFS, 32'h0);
    bus(1'b1, SPC_SCAN_OFS, 32'h3c);
    rd_chk("scan 60", SPC_SCAN_OFS, 32'h3c);
    $display("test period done");
  endtask
  task automatic t_pace(input logic [5:0] p, input int lo, input int hi);
    bus(1'b1, SPC_CTRL_OFS, 32'h9);
    bus(1'b1, SPC_SCAN_OFS, {26'h0, p});
    bus(1'b1, SPC_CTRL_OFS, 32'h5);
    gap(n);
    gap(n);
    `CHK("gap low", 1'b1, n >= lo)
    `CHK("gap high", 1'b1, n <= hi)
    $display("test pace %0d done, gap %0d", p, n);
  endtask
  task automatic t_retain();
    bus(1'b1, SPC_RETAIN_OFS, 32'hffff);
    rd_chk("retain all", SPC_RETAIN_OFS, 32'h3ff);
    bus(1'b1, SPC_RETAIN_OFS, 32'h188);
    rd_chk("retain grp", SPC_RETAIN_OFS, 32'h188);
    `CHK("mask", 10'h188, retain_mask)
    power_fail <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (nv_store !== 1'b1 && n < 6);
    `CHK("store", 1'b1, nv_store)
    power_fail <= 1'b0;
    sys_locked <= 1'b1;
    bus(1'b1, SPC_RETAIN_OFS, 32'h0);
    rd_chk("locked", SPC_RETAIN_OFS, 32'h188);
    sys_locked <= 1'b0;
    $display("test retain done");
  endtask
  task automatic t_startup();
    prog_valid <= 1'b0;
    do_reset();
    `CHK("no prog", 1'b0, run_mode)
    prog_valid <= 1'b1;
    has_display <= 1'b0;
    fitted <= 1'b1;
    do_reset();
    `CHK("no display", 1'b1, run_mode)
    rd_chk("ctrl kept", SPC_CTRL_OFS, 32'h1);
    $display("test startup done");
  endtask
  // Supply drop and return, then let the startup check settle
  task automatic power_cycle(input int settle);
    power_fail <= 1'b1;
    repeat (3) @(posedge ref_clk);
    power_fail <= 1'b0;
    repeat (settle) @(posedge ref_clk);
  endtask
  task automatic t_card();
    bus(1'b1, SPC_CTRL_OFS, 32'h0);
    power_cycle(6);
    `CHK("autostart off", 1'b0, run_mode)
    has_display <= 1'b0;
    power_cycle(6);
    `CHK("displayless", 1'b1, run_mode)
    has_display <= 1'b1;
    cfg <= 3'h3;
    fitted <= 1'b1;
    bus(1'b1, SPC_CTRL_OFS, 32'h3);
    power_cycle(6);
    `CHK("card run", 1'b1, run_mode)
    fitted <= 1'b0;
    power_cycle(6);
    `CHK("card absent", 1'b0, run_mode)
    cfg <= 3'h4;
    fitted <= 1'b1;
    power_cycle(6);
    `CHK("old module", 1'b1, run_mode)
    `CHK("old no load", 1'b0, load_req)
    cfg <= 3'h7;
    power_cycle(3);
    `CHK("loading", 1'b1, load_req)
    `CHK("load no run", 1'b0, run_mode)
    repeat (6) @(posedge ref_clk);
    `CHK("loaded run", 1'b1, run_mode)
    rd_chk("ctrl after load", SPC_CTRL_OFS, 32'h3);
    bus(1'b1, SPC_CTRL_OFS, 32'h1);
    $display("test card done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    {hsel, hwrite, power_fail, sys_locked, fitted} = 5'h0;
    srst = 1'b1;
    {haddr, hwdata, htrans, eng, scan_done} = '0;
    hsize = 3'h2;
    cfg = 3'h7;
    has_display = 1'b1;
    prog_valid = 1'b1;
    do_reset();
    t_defaults();
    t_period();
    t_pace(6'h3, 3 * CPM, 3 * CPM + 3);
    t_pace(6'h0, 5, 8);
    t_retain();
    t_card();
    t_startup();
    tally_and_finish();
  end
endmodule // testbench
